/* core/lfb_host.sv */
// Host controller for a two-port stack/queue buffer, driven over APB.
// Assumes an APB master on clk; device pins are asynchronous.
// What this block does
// - The heading is set, and settled, before any access on a port.
// - For stack use on one port, a control write flips the heading between store and fetch.
// - An access starts on select low and moves its word on select rise.
// - Transfers come no faster than 650 kHz on the slower grade.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module lfb_host #(
   parameter int DATA_W = 9
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Device control pins
   output logic                   flow_heading,
   output logic                   depth_select,
   output logic                   master_clear,
   input  wire logic              empty,
   input  wire logic              full,
   // Device port A
   output logic                   port_a_select_n,
   input  wire logic [DATA_W-1:0] port_a_lines_i,
   output logic      [DATA_W-1:0] port_a_lines_o,
   output logic      [DATA_W-1:0] port_a_lines_oe,
   // Device port B
   output logic                   port_b_select_n,
   input  wire logic [DATA_W-1:0] port_b_lines_i,
   output logic      [DATA_W-1:0] port_b_lines_o,
   output logic      [DATA_W-1:0] port_b_lines_oe
);
   localparam logic [4:0] MR_M1  = 5'(lfb_pkg::MR_CYC - 1);
   localparam logic [4:0] DIR_M1 = 5'(lfb_pkg::DIR_CYC - 1);

   lfb_pkg::lfb_host_state_t  state_reg;
   logic [lfb_pkg::CNT_W-1:0] cnt_reg;
   logic                      empty_s1_reg, empty_s2_reg;
   logic                      full_s1_reg, full_s2_reg;
   logic                      refused_reg;
   logic                      port_b_reg;
   logic [DATA_W-1:0]         word_reg;
   logic                      start_a, start_b, done_a, done_b;
   logic [DATA_W-1:0]         rdata_a, rdata_b;
   logic                      wr_access, hit_ctrl, hit_cmd, hit_stat;
   logic                      cmd_port_b, cmd_wr, cmd_ok, refuse_set;

   if (DATA_W != 9) begin : g_chk
      $error("lfb_host: device words are nine bits");
   end

   // Flag synchronisers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         empty_s1_reg <= 1'b1;
         empty_s2_reg <= 1'b1;
         full_s1_reg  <= 1'b0;
         full_s2_reg  <= 1'b0;
      end else begin
         empty_s1_reg <= empty;
         empty_s2_reg <= empty_s1_reg;
         full_s1_reg  <= full;
         full_s2_reg  <= full_s1_reg;
      end
   end

   // Access decode; APB never waits
   assign pready    = 1'b1;
   assign wr_access = psel && penable && pwrite;
   assign hit_ctrl  = wr_access && paddr == lfb_pkg::A_CTRL;
   assign hit_cmd   = wr_access && paddr == lfb_pkg::A_CMD;
   assign hit_stat  = wr_access && paddr == lfb_pkg::A_STAT;
   assign cmd_port_b = pwdata[lfb_pkg::CMD_PORT];
   assign cmd_wr = cmd_port_b ? !flow_heading : flow_heading;
   // never write full or read empty
   assign cmd_ok = state_reg == lfb_pkg::LFB_IDLE &&
                   !(cmd_wr ? full_s2_reg : empty_s2_reg);
   assign start_a = hit_cmd && cmd_ok && !cmd_port_b;
   assign start_b = hit_cmd && cmd_ok && cmd_port_b;
   assign refuse_set = (hit_cmd && !cmd_ok) ||
                       (hit_ctrl && state_reg != lfb_pkg::LFB_IDLE);

   // Read data and error, latched in the setup cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= '0;
         pslverr <= 1'b0;
         case (paddr)
            lfb_pkg::A_CTRL: begin
               prdata[lfb_pkg::CTRL_HEAD]  <= flow_heading;
               prdata[lfb_pkg::CTRL_DEPTH] <= depth_select;
            end
            lfb_pkg::A_CMD: prdata[lfb_pkg::CMD_PORT] <= port_b_reg;
            lfb_pkg::A_STAT: begin
               prdata[lfb_pkg::ST_BUSY]    <= state_reg != lfb_pkg::LFB_IDLE;
               prdata[lfb_pkg::ST_EMPTY]   <= empty_s2_reg;
               prdata[lfb_pkg::ST_FULL]    <= full_s2_reg;
               prdata[lfb_pkg::ST_REFUSED] <= refused_reg;
               prdata[lfb_pkg::ST_HEAD]    <= flow_heading;
               prdata[lfb_pkg::ST_DEPTH]   <= depth_select;
            end
            lfb_pkg::A_RDATA: prdata[DATA_W-1:0] <= word_reg;
            default: pslverr <= 1'b1;
         endcase
      end
   end

   // Refused flag: set wins over clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         refused_reg <= 1'b0;
      end else if (refuse_set) begin
         refused_reg <= 1'b1;
      end else if (hit_stat && pwdata[lfb_pkg::ST_REFUSED]) begin
         refused_reg <= 1'b0;
      end
   end

   // Sequencer: heading settle, clear pulse, transfers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg    <= lfb_pkg::LFB_DIRW;
         cnt_reg      <= '0;
         flow_heading <= lfb_pkg::HEAD_RST;
         depth_select <= lfb_pkg::DEPTH_RST;
         master_clear <= 1'b0;
         port_b_reg   <= 1'b0;
         word_reg     <= '0;
      end else begin
         case (state_reg)
            lfb_pkg::LFB_IDLE: begin
               cnt_reg <= '0;
               if (hit_ctrl) begin
                  depth_select <= pwdata[lfb_pkg::CTRL_DEPTH];
                  flow_heading <= pwdata[lfb_pkg::CTRL_HEAD];
                  if (pwdata[lfb_pkg::CTRL_CLEAR]) begin
                     master_clear <= 1'b1;
                     state_reg    <= lfb_pkg::LFB_CLEAR;
                  end else if (pwdata[lfb_pkg::CTRL_HEAD] != flow_heading) begin
                     state_reg <= lfb_pkg::LFB_DIRW;
                  end
               end else if (start_a || start_b) begin
                  port_b_reg <= cmd_port_b;
                  state_reg  <= lfb_pkg::LFB_XFER;
               end
            end
            lfb_pkg::LFB_CLEAR: begin
               if (cnt_reg == MR_M1) begin
                  master_clear <= 1'b0;
                  cnt_reg      <= '0;
                  state_reg    <= lfb_pkg::LFB_DIRW;
               end else begin
                  cnt_reg <= cnt_reg + 5'h1;
               end
            end
            lfb_pkg::LFB_DIRW: begin
               if (cnt_reg == DIR_M1) begin
                  state_reg <= lfb_pkg::LFB_IDLE;
               end else begin
                  cnt_reg <= cnt_reg + 5'h1;
               end
            end
            lfb_pkg::LFB_XFER: begin
               if (done_a || done_b) begin
                  if (!(port_b_reg ? !flow_heading : flow_heading)) begin
                     word_reg <= port_b_reg ? rdata_b : rdata_a;
                  end
                  state_reg <= lfb_pkg::LFB_IDLE;
               end
            end
            default: state_reg <= lfb_pkg::LFB_IDLE;
         endcase
      end
   end

   // Port A strobe sequencer
   lfb_port #(.DATA_W(DATA_W)) u_port_a (
      .clk      (clk),
      .reset_n  (reset_n),
      .start    (start_a),
      .wr       (cmd_wr),
      .wdata    (pwdata[DATA_W-1:0]),
      .rdata    (rdata_a),
      .done     (done_a),
      .select_n (port_a_select_n),
      .lines_i  (port_a_lines_i),
      .lines_o  (port_a_lines_o),
      .lines_oe (port_a_lines_oe)
   );

   // Port B strobe sequencer
   lfb_port #(.DATA_W(DATA_W)) u_port_b (
      .clk      (clk),
      .reset_n  (reset_n),
      .start    (start_b),
      .wr       (cmd_wr),
      .wdata    (pwdata[DATA_W-1:0]),
      .rdata    (rdata_b),
      .done     (done_b),
      .select_n (port_b_select_n),
      .lines_i  (port_b_lines_i),
      .lines_o  (port_b_lines_o),
      .lines_oe (port_b_lines_oe)
   );

   // Checker helper: cycles since heading last changed
   logic       head_prev_reg;
   logic [5:0] dir_age_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         head_prev_reg <= lfb_pkg::HEAD_RST;
         dir_age_reg   <= '0;
      end else begin
         head_prev_reg <= flow_heading;
         if (flow_heading != head_prev_reg) begin
            dir_age_reg <= '0;
         end else if (dir_age_reg != 6'h3F) begin
            dir_age_reg <= dir_age_reg + 6'h01;
         end
      end
   end

   property p_clear_len;
      @(posedge clk) disable iff (!reset_n)
      $rose(master_clear) |-> master_clear[*8] ##1 !master_clear;
   endproperty
   a_clear_len: assert property (p_clear_len)
      else $error("clear pulse length wrong");

   property p_dir_setup;
      @(posedge clk) disable iff (!reset_n)
      ($fell(port_a_select_n) || $fell(port_b_select_n)) |->
         dir_age_reg >= 6'(lfb_pkg::DIR_CYC);
   endproperty
   a_dir_setup: assert property (p_dir_setup)
      else $error("access too soon after heading change");

   property p_heading_hold;
      @(posedge clk) disable iff (!reset_n)
      (!port_a_select_n || !port_b_select_n) |-> $stable(flow_heading);
   endproperty
   a_heading_hold: assert property (p_heading_hold)
      else $error("heading changed during access");

   property p_port_role;
      @(posedge clk) disable iff (!reset_n)
      ((|port_a_lines_oe) |-> flow_heading) and
      ((|port_b_lines_oe) |-> !flow_heading);
   endproperty
   a_port_role: assert property (p_port_role)
      else $error("port drove against heading");

   property p_refuse;
      @(posedge clk) disable iff (!reset_n)
      (hit_cmd && state_reg == lfb_pkg::LFB_IDLE && cmd_wr && full_s2_reg)
         |=> state_reg == lfb_pkg::LFB_IDLE && refused_reg;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("write issued while full");

   c_clear: cover property (@(posedge clk) disable iff (!reset_n)
      $fell(master_clear));
   c_refused: cover property (@(posedge clk) disable iff (!reset_n)
      $rose(refused_reg));
endmodule

/* core/lfb_pkg.sv */
// Shared constants and types for the stack-buffer host controller.
// Assumes a 20 MHz system clock and the slower device speed grade.
package lfb_pkg;
   // Clock period and device timing, in nanoseconds
   localparam int CLK_NS    = 50;
   localparam int T_MR_NS   = 400;   // Clear pulse, least
   localparam int T_DIR_NS  = 1500;  // Heading setup, least
   localparam int T_CSL_NS  = 600;   // Select low, least
   localparam int T_CSH_NS  = 600;   // Select high, least
   localparam int T_CY_NS   = 1540;  // Transfer period, least
   localparam int T_DV_NS   = 550;   // Read data valid, most
   localparam int T_DH_NS   = 150;   // Write data hold, least
   localparam int T_FV_NS   = 550;   // Flags valid, most
   localparam int SYNC_CYC  = 2;     // Pin synchroniser depth

   // Cycle counts, rounded up
   localparam int MR_CYC  = (T_MR_NS + CLK_NS - 1) / CLK_NS;
   localparam int DIR_CYC = (T_DIR_NS + CLK_NS - 1) / CLK_NS;
   localparam int CSL_CYC = (T_CSL_NS + CLK_NS - 1) / CLK_NS;
   localparam int CSH_CYC = (T_CSH_NS + CLK_NS - 1) / CLK_NS;
   localparam int CY_CYC  = (T_CY_NS + CLK_NS - 1) / CLK_NS;
   localparam int DV_CYC  = (T_DV_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1;
   localparam int FV_CYC  = (T_FV_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1;
   localparam int HOLD_CYC = (T_DH_NS + CLK_NS - 1) / CLK_NS;
   localparam int LOW_CYC = (CSL_CYC > DV_CYC) ? CSL_CYC : DV_CYC;
   localparam int HI_A    = (CSH_CYC > CY_CYC - LOW_CYC) ?
                            CSH_CYC : CY_CYC - LOW_CYC;
   localparam int HIGH_CYC = (HI_A > FV_CYC) ? HI_A : FV_CYC;
   localparam int CNT_W   = 5;

   // Register offsets
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_CMD   = 8'h04;
   localparam logic [7:0] A_STAT  = 8'h08;
   localparam logic [7:0] A_RDATA = 8'h0C;

   // Field positions
   localparam int CTRL_HEAD  = 0;
   localparam int CTRL_DEPTH = 1;
   localparam int CTRL_CLEAR = 2;
   localparam int CMD_PORT   = 9;
   localparam int ST_BUSY    = 0;
   localparam int ST_EMPTY   = 1;
   localparam int ST_FULL    = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_HEAD    = 4;
   localparam int ST_DEPTH   = 5;

   // Reset values
   localparam logic HEAD_RST  = 1'b1;
   localparam logic DEPTH_RST = 1'b1;

   // Host sequencer states
   typedef enum logic [1:0] {
      LFB_IDLE  = 2'b00,
      LFB_XFER  = 2'b01,
      LFB_DIRW  = 2'b11,
      LFB_CLEAR = 2'b10
   } lfb_host_state_t;

   // Port strobe states
   typedef enum logic [1:0] {
      LFB_P_IDLE = 2'b00,
      LFB_P_LOW  = 2'b01,
      LFB_P_HIGH = 2'b11
   } lfb_port_state_t;
endpackage

/* core/lfb_port.sv */
// One port strobe sequencer: drives select and data lines of one port.
// Assumes start only while idle; lines_i comes from device pins.
`timescale 1ns/100ps
module lfb_port #(
   parameter int DATA_W = 9
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Transfer request
   input  wire logic              start,
   input  wire logic              wr,
   input  wire logic [DATA_W-1:0] wdata,
   output logic      [DATA_W-1:0] rdata,
   output logic                   done,
   // Device port pins
   output logic                   select_n,
   input  wire logic [DATA_W-1:0] lines_i,
   output logic      [DATA_W-1:0] lines_o,
   output logic      [DATA_W-1:0] lines_oe
);
   localparam logic [4:0] LOW_M1  = 5'(lfb_pkg::LOW_CYC - 1);
   localparam logic [4:0] HIGH_M1 = 5'(lfb_pkg::HIGH_CYC - 1);
   localparam logic [4:0] HOLD_M1 = 5'(lfb_pkg::HOLD_CYC - 1);

   lfb_pkg::lfb_port_state_t     state_reg;
   logic [lfb_pkg::CNT_W-1:0]    cnt_reg;
   logic                         wr_reg;
   logic [DATA_W-1:0]            lines_s1_reg;
   logic [DATA_W-1:0]            lines_s2_reg;

   // Counts must fit the counter
   if (lfb_pkg::LOW_CYC > 31 || lfb_pkg::HIGH_CYC > 31 ||
       lfb_pkg::HOLD_CYC >= lfb_pkg::HIGH_CYC || DATA_W < 1) begin : g_chk
      $error("lfb_port: timing counts out of range");
   end

   // Two-stage pin synchroniser
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lines_s1_reg <= '0;
         lines_s2_reg <= '0;
      end else begin
         lines_s1_reg <= lines_i;
         lines_s2_reg <= lines_s1_reg;
      end
   end

   // Strobe sequence: low phase, then high phase
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= lfb_pkg::LFB_P_IDLE;
         cnt_reg   <= '0;
         wr_reg    <= 1'b0;
         select_n  <= 1'b1;
         lines_o   <= '0;
         lines_oe  <= '0;
         rdata     <= '0;
         done      <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_reg)
            lfb_pkg::LFB_P_IDLE: begin
               if (start) begin
                  wr_reg    <= wr;
                  select_n  <= 1'b0;
                  lines_o   <= wdata;
                  lines_oe  <= {DATA_W{wr}};
                  cnt_reg   <= '0;
                  state_reg <= lfb_pkg::LFB_P_LOW;
               end
            end
            lfb_pkg::LFB_P_LOW: begin
               if (cnt_reg == LOW_M1) begin
                  select_n <= 1'b1;
                  if (!wr_reg) begin
                     rdata <= lines_s2_reg;
                  end
                  cnt_reg   <= '0;
                  state_reg <= lfb_pkg::LFB_P_HIGH;
               end else begin
                  cnt_reg <= cnt_reg + 5'h1;
               end
            end
            lfb_pkg::LFB_P_HIGH: begin
               if (cnt_reg == HOLD_M1) begin
                  lines_oe <= '0;
               end
               if (cnt_reg == HIGH_M1) begin
                  done      <= 1'b1;
                  state_reg <= lfb_pkg::LFB_P_IDLE;
               end else begin
                  cnt_reg <= cnt_reg + 5'h1;
               end
            end
            default: state_reg <= lfb_pkg::LFB_P_IDLE;
         endcase
      end
   end

   // Checker helpers: low length and period since last fall
   logic [5:0] low_len_reg;
   logic [5:0] gap_reg;
   logic       sel_prev_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_len_reg  <= '0;
         gap_reg      <= 6'h3F;
         sel_prev_reg <= 1'b1;
      end else begin
         sel_prev_reg <= select_n;
         low_len_reg  <= select_n ? 6'h00 : low_len_reg + 6'h01;
         if (sel_prev_reg && !select_n) begin
            gap_reg <= 6'h01;
         end else if (gap_reg != 6'h3F) begin
            gap_reg <= gap_reg + 6'h01;
         end
      end
   end

   property p_low_len;
      @(posedge clk) disable iff (!reset_n)
      $rose(select_n) |-> low_len_reg == 6'(lfb_pkg::LOW_CYC);
   endproperty
   a_low_len: assert property (p_low_len)
      else $error("select low time wrong");

   property p_write_hold;
      @(posedge clk) disable iff (!reset_n)
      ($rose(select_n) && wr_reg) |->
         (lines_oe == {DATA_W{1'b1}})[*3] ##1 (lines_oe == '0);
   endproperty
   a_write_hold: assert property (p_write_hold)
      else $error("write data hold wrong");

   property p_read_release;
      @(posedge clk) disable iff (!reset_n)
      (!select_n && !wr_reg) |-> lines_oe == '0;
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("host drove lines during read");

   property p_rate;
      @(posedge clk) disable iff (!reset_n)
      (sel_prev_reg && !select_n) |-> gap_reg >= 6'(lfb_pkg::CY_CYC);
   endproperty
   a_rate: assert property (p_rate)
      else $error("transfers too close");

   c_write: cover property (@(posedge clk) disable iff (!reset_n)
      $rose(select_n) && wr_reg);
   c_read: cover property (@(posedge clk) disable iff (!reset_n)
      $rose(select_n) && !wr_reg);
endmodule

/* sim/lfb_dev_model.sv */
// Behavioural model of the two-port stack/queue buffer at the far side.
// Assumes the bench resolves each port wire from host and model drives.
`timescale 1ns/100ps
module lfb_dev_model #(
   parameter int DV_NS = 550
) (
   // Control pins
   input  wire logic       flow_heading,
   input  wire logic       depth_select,
   input  wire logic       master_clear,
   // Port strobes and resolved wire levels
   input  wire logic       port_a_select_n,
   input  wire logic       port_b_select_n,
   input  wire logic [8:0] port_a_lines,
   input  wire logic [8:0] port_b_lines,
   // Flags and model drive values
   output logic            empty,
   output logic            full,
   output logic [8:0]      a_drv,
   output logic [8:0]      b_drv
);
   logic [8:0] mem[$];
   int         cnt    = 0;
   logic       last_b = 1'b0;
   // Set by a real fall; an unknown-to-high select out of reset is no rise
   logic       a_low  = 1'b0;
   logic       b_low  = 1'b0;
   int         depth;

   assign depth = depth_select ? 132 : 128;
   assign empty = (cnt == 0);
   assign full  = (cnt >= depth);

   function automatic logic [8:0] peek(input logic pb);
      return (pb == last_b) ? mem[$] : mem[0];
   endfunction

   // One word moves per select rise
   task automatic xfer(input logic pb, input logic [8:0] w);
      if (master_clear) return;
      if (pb ^ flow_heading) begin
         if (cnt < depth) begin
            mem.push_back(w);
            last_b = pb;
         end
      end else if (cnt > 0) begin
         if (pb == last_b) void'(mem.pop_back());
         else void'(mem.pop_front());
      end
      cnt = mem.size();
   endtask

   initial begin
      a_drv = 9'h0AA;
      b_drv = 9'h155;
   end

   // Ports apart; data while low, inverse once freed
   always @(negedge port_a_select_n) begin
      a_low = 1'b1;
      if (!flow_heading && cnt > 0) a_drv <= #(DV_NS) peek(1'b0);
   end
   always @(posedge port_a_select_n) begin
      if (a_low) begin
         a_low = 1'b0;
         a_drv = ~a_drv;
         xfer(1'b0, port_a_lines);
      end
   end
   always @(negedge port_b_select_n) begin
      b_low = 1'b1;
      if (flow_heading && cnt > 0) b_drv <= #(DV_NS) peek(1'b1);
   end
   always @(posedge port_b_select_n) begin
      if (b_low) begin
         b_low = 1'b0;
         b_drv = ~b_drv;
         xfer(1'b1, port_b_lines);
      end
   end

   always @(posedge master_clear) begin
      mem.delete();
      cnt = 0;
   end
endmodule

/* sim/test_lfb_host.sv */
// Self-checking bench for the stack-buffer host, driven over APB.
// Assumes the device model answers on both ports with its slow timing.
`timescale 1ns/100ps
module test_lfb_host;
   logic        clk     = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, r;
   logic        pready, pslverr, err, head, dsel, mclr, empty, full;
   logic        sel_a_n, sel_b_n;
   logic [8:0]  a_o, a_oe, b_o, b_oe, a_drv, b_drv, a_wire, b_wire;
   int          fails    = 0;
   int          compares = 0;

   always #25 clk = ~clk;
   // Wire level from both parties
   assign a_wire = (a_oe & a_o) | (~a_oe & a_drv);
   assign b_wire = (b_oe & b_o) | (~b_oe & b_drv);

   lfb_host u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flow_heading(head), .depth_select(dsel), .master_clear(mclr),
      .empty(empty), .full(full), .port_a_select_n(sel_a_n),
      .port_a_lines_i(a_wire), .port_a_lines_o(a_o),
      .port_a_lines_oe(a_oe), .port_b_select_n(sel_b_n),
      .port_b_lines_i(b_wire), .port_b_lines_o(b_o),
      .port_b_lines_oe(b_oe));

   lfb_dev_model u_dev (.flow_heading(head), .depth_select(dsel),
      .master_clear(mclr), .port_a_select_n(sel_a_n),
      .port_b_select_n(sel_b_n), .port_a_lines(a_wire),
      .port_b_lines(b_wire), .empty(empty), .full(full),
      .a_drv(a_drv), .b_drv(b_drv));

   task automatic final_report();
      if (fails == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; read data and error land in r and err
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Poll status until not busy
   task automatic idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, lfb_pkg::A_STAT, 32'h0);
         n++;
      end while (r[lfb_pkg::ST_BUSY] !== 1'b0 && n < 100);
      if (n >= 100) fails++;
   endtask

   task automatic cmd(input logic pb, input logic [8:0] d);
      apb(1'b1, lfb_pkg::A_CMD, {22'h0, pb, d});
      idle();
   endtask

   task automatic flags(input logic e, input logic f);
      apb(1'b0, lfb_pkg::A_STAT, 32'h0);
      chk({r[lfb_pkg::ST_FULL], r[lfb_pkg::ST_EMPTY]}, {f, e});
   endtask

   task automatic rd(input logic pb, input logic [8:0] exp);
      cmd(pb, 9'h000);
      apb(1'b0, lfb_pkg::A_RDATA, 32'h0);
      chk(r[8:0], exp);
   endtask

   task automatic t_reset();
      apb(1'b0, lfb_pkg::A_CTRL, 32'h0);
      chk(r[1:0], {lfb_pkg::DEPTH_RST, lfb_pkg::HEAD_RST});
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      idle();
      flags(1'b1, 1'b0);
   endtask

   task automatic t_fifo();
      logic [8:0] v[3];
      v = '{9'h1A5, 9'h05A, 9'h100};
      foreach (v[i]) cmd(1'b0, v[i]);
      flags(1'b0, 1'b0);
      foreach (v[i]) rd(1'b1, v[i]);
      flags(1'b1, 1'b0);
   endtask

   task automatic t_lifo();
      cmd(1'b0, 9'h011);
      cmd(1'b0, 9'h122);
      apb(1'b1, lfb_pkg::A_CTRL, 32'h2);
      idle();
      rd(1'b0, 9'h122);
      rd(1'b0, 9'h011);
      cmd(1'b0, 9'h000);
      chk(r[lfb_pkg::ST_REFUSED], 32'h1);
      apb(1'b1, lfb_pkg::A_STAT, 32'h8);
      cmd(1'b1, 9'h033);
      chk(r[lfb_pkg::ST_REFUSED], 32'h0);
      apb(1'b0, lfb_pkg::A_CMD, 32'h0);
      chk(r[lfb_pkg::CMD_PORT], 32'h1);
      apb(1'b1, lfb_pkg::A_CTRL, 32'h3);
      idle();
      rd(1'b1, 9'h033);
   endtask

   task automatic t_depth();
      apb(1'b1, lfb_pkg::A_CTRL, 32'h5);
      idle();
      for (int i = 0; i < 128; i++) begin
         if (i == 127) flags(1'b0, 1'b0);
         cmd(1'b0, 9'(i));
      end
      flags(1'b0, 1'b1);
      cmd(1'b0, 9'h1FF);
      chk(r[lfb_pkg::ST_REFUSED], 32'h1);
      rd(1'b1, 9'h000);
      apb(1'b1, lfb_pkg::A_CTRL, 32'h7);
      idle();
      flags(1'b1, 1'b0);
      for (int i = 0; i < 132; i++) begin
         if (i == 128) flags(1'b0, 1'b0);
         cmd(1'b0, 9'(i));
      end
      flags(1'b0, 1'b1);
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_fifo();
      t_lifo();
      t_depth();
      final_report();
   end

   // Watchdog against a hang
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      final_report();
   end
endmodule
